// *** shared/timer_window_capture_ppg_defs.vh ***
// Constants for the window, capture and pulse generation timer.
// Included by every design file of the block; holds definitions only.
`ifndef TIMER_WINDOW_CAPTURE_PPG_DEFS_VH
`define TIMER_WINDOW_CAPTURE_PPG_DEFS_VH

// Register byte addresses
`define ADDR_CTRL 8'h00
`define ADDR_PERIOD 8'h04
`define ADDR_CMP 8'h08
`define ADDR_STATUS 8'h0C

// Control register fields
`define MODE_MSB 2
`define MODE_LSB 0
`define CLKSEL_MSB 4
`define CLKSEL_LSB 3
`define START_MSB 6
`define START_LSB 5
`define SINGLE_BIT 7
`define ONESHOT_BIT 8
`define FF_BIT 9
`define CTRL_MASK 32'h000003FF
`define CTRL_RESET 32'h00000000

// Status register fields
`define STAT_RUN_BIT 16
`define STAT_PIN_BIT 17
`define STAT_IN_BIT 18

// Mode codes
`define MODE_TIMER 3'h0
`define MODE_WINDOW 3'h1
`define MODE_PWM 3'h2
`define MODE_PPG 3'h3

// Start control codes
`define START_STOP 2'h0
`define START_CMD 2'h1
`define START_RISE 2'h2
`define START_FALL 2'h3

// Counter values
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define REG16_RESET 16'h0000

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** hdl/input_edge.v ***
// Edge detector for the timer input pin.
// Assumes the pin is already synchronous to aclk.
`include "timer_window_capture_ppg_defs.vh"
module input_edge
(
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Pin
   input wire pin,
   // Detected level and edges
   output reg level_r,
   output wire rise,
   output wire fall
);
   reg prev_r;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         // Seeded from the pin: a high idle level gives no false edge after reset
         level_r <= pin;
         prev_r <= pin;
      end
      else
      begin
         level_r <= pin;
         prev_r <= level_r;
      end
   end

   assign rise = level_r & ~prev_r;
   assign fall = ~level_r & prev_r;
endmodule

// *** hdl/source_prescaler.v ***
// Internal source clock generator: a one-cycle tick at the selected division.
// Assumes aclk is the undivided system clock.
`include "timer_window_capture_ppg_defs.vh"
module source_prescaler #(
   parameter PRE_W = 11,
   parameter SHIFT0 = 11,
   parameter SHIFT1 = 7,
   parameter SHIFT2 = 3,
   parameter SHIFT3 = 0
)
(
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Division select
   input wire [1:0] sel,
   // Source clock tick
   output reg tick_r
);
   reg [PRE_W-1:0] pre_r;
   reg [PRE_W-1:0] mask;
   integer sh;

   always @*
   begin
      sh = SHIFT3;
      if (sel == 2'h0)
         sh = SHIFT0;
      else if (sel == 2'h1)
         sh = SHIFT1;
      else if (sel == 2'h2)
         sh = SHIFT2;
      mask = {PRE_W{1'b1}} >> (PRE_W - sh);
      if (sh == 0)
         mask = {PRE_W{1'b0}};
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pre_r <= {PRE_W{1'b0}};
         tick_r <= 1'b0;
      end
      else
      begin
         pre_r <= pre_r + {{(PRE_W-1){1'b0}}, 1'b1};
         tick_r <= ((pre_r & mask) == mask);
      end
   end
endmodule

// *** hdl/timer_window_capture_ppg.v ***
// Window-gated counter, pulse width capture and programmable pulse output.
// Assumes an AXI4-Lite master on aclk and a timer input synchronous to aclk.
//
// Functional notes
// - Window mode counts source ticks ANDed with window
// - Window polarity selectable high or low
// - Window period match interrupts and clears counter
// - Measurement starts on selected trigger edge
// - Single capture: opposite edge captures, loads counter with one, waits
// - Double capture: both edges capture, trigger clears
// - Single capture holds counter at one
// - Pulse generation starts by edge or command
// - Continuous: compare and period matches toggle output
// - Stopping holds the pulse output level
// - One-shot: period match toggles, clears start, stops
// - Output pin is inverse of flip-flop
// - Flip-flop resets to zero
// - Write after odd toggles loads inverted bit
`include "timer_window_capture_ppg_defs.vh"
module timer_window_capture_ppg #(
   parameter CNT_W = 16,
   parameter ADDR_W = 8,
   parameter PRE_W = 11,
   parameter SHIFT0 = 11,
   parameter SHIFT1 = 7,
   parameter SHIFT2 = 3,
   parameter SHIFT3 = 0
)
(
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Timer pins
   input wire timer_input_pin,
   output reg pulse_output_pin,
   output reg timer_irq
);
   reg [31:0] timer_control_reg;
   reg [CNT_W-1:0] period_compare_reg, capture_compare_reg, cnt_r;
   reg run_r, ff_r, inv_r, aw_have_r, w_have_r;
   reg [ADDR_W-1:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;

   wire in_level, in_rise, in_fall, tick;
   wire [31:0] byte_mask, ctrl_merged, period_merged, cmp_merged;
   wire do_write, wr_ctrl, wr_period, wr_cmp, wr_hit;
   wire [2:0] mode, new_mode;
   wire [1:0] start;
   wire single, oneshot, trig_edge, opp_edge, win_open;
   wire cnt_is_period, cnt_is_cmp;
   wire [CNT_W-1:0] cnt_inc;

   input_edge u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(timer_input_pin),
      .level_r(in_level),
      .rise(in_rise),
      .fall(in_fall)
   );

   source_prescaler #(
      .PRE_W(PRE_W),
      .SHIFT0(SHIFT0),
      .SHIFT1(SHIFT1),
      .SHIFT2(SHIFT2),
      .SHIFT3(SHIFT3)
   ) u_pre (
      .aclk(aclk),
      .aresetn(aresetn),
      .sel(timer_control_reg[`CLKSEL_MSB:`CLKSEL_LSB]),
      .tick_r(tick)
   );

   assign mode = timer_control_reg[`MODE_MSB:`MODE_LSB];
   assign start = timer_control_reg[`START_MSB:`START_LSB];
   assign single = timer_control_reg[`SINGLE_BIT];
   assign oneshot = timer_control_reg[`ONESHOT_BIT];
   // Falling selected only by its own code; command start uses rising
   assign trig_edge = (start == `START_FALL) ? in_fall : in_rise;
   assign opp_edge = (start == `START_FALL) ? in_rise : in_fall;
   assign win_open = in_level ^ (start == `START_FALL);
   assign cnt_is_period = (cnt_r == period_compare_reg);
   assign cnt_is_cmp = (cnt_r == capture_compare_reg);
   assign cnt_inc = cnt_r + `CNT_ONE;

   // Write path: address and data are latched independently, in any order
   assign byte_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
   assign do_write = aw_have_r & w_have_r;
   assign wr_ctrl = do_write & (aw_addr_r == `ADDR_CTRL);
   assign wr_period = do_write & (aw_addr_r == `ADDR_PERIOD);
   assign wr_cmp = do_write & (aw_addr_r == `ADDR_CMP);
   assign wr_hit = wr_ctrl | wr_period | wr_cmp;
   assign ctrl_merged = ((timer_control_reg & ~byte_mask) | (w_data_r & byte_mask)) & `CTRL_MASK;
   assign period_merged = ({16'h0000, period_compare_reg} & ~byte_mask) | (w_data_r & byte_mask);
   assign cmp_merged = ({16'h0000, capture_compare_reg} & ~byte_mask) | (w_data_r & byte_mask);
   assign new_mode = ctrl_merged[`MODE_MSB:`MODE_LSB];

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= {ADDR_W{1'b0}};
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write)
         begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_hit || aw_addr_r == `ADDR_STATUS) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Read path: one outstanding read, answered the cycle after the address
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RESP_OKAY;
         if (s_axi_araddr == `ADDR_CTRL)
            s_axi_rdata <= timer_control_reg;
         else if (s_axi_araddr == `ADDR_PERIOD)
            s_axi_rdata <= {16'h0000, period_compare_reg};
         else if (s_axi_araddr == `ADDR_CMP)
            s_axi_rdata <= {16'h0000, capture_compare_reg};
         else if (s_axi_araddr == `ADDR_STATUS)
            s_axi_rdata <= {13'h0000, in_level, pulse_output_pin, run_r, cnt_r};
         else
         begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
         end
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         period_compare_reg <= `REG16_RESET;
      else if (wr_period)
         period_compare_reg <= period_merged[CNT_W-1:0];
   end

   // Timer core. A control write takes the cycle; counting resumes next cycle.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         timer_control_reg <= `CTRL_RESET;
         capture_compare_reg <= `REG16_RESET;
         cnt_r <= `CNT_ZERO;
         run_r <= 1'b0;
         ff_r <= 1'b0;
         inv_r <= 1'b0;
         timer_irq <= 1'b0;
         pulse_output_pin <= 1'b1;
      end
      else
      begin
         timer_irq <= 1'b0;
         pulse_output_pin <= ~ff_r;
         if (wr_cmp)
            capture_compare_reg <= cmp_merged[CNT_W-1:0];
         if (wr_ctrl)
         begin
            timer_control_reg <= ctrl_merged;
            if (new_mode == `MODE_PPG && mode != `MODE_PPG)
            begin
               ff_r <= ctrl_merged[`FF_BIT];
               inv_r <= 1'b0;
            end
            else if (new_mode == `MODE_PPG)
               // Flip-flop only tracks start level if no odd toggle pending
               ff_r <= ctrl_merged[`FF_BIT] ^ inv_r;
            if (ctrl_merged[`START_MSB:`START_LSB] == `START_STOP || new_mode != mode)
            begin
               run_r <= 1'b0;
               cnt_r <= `CNT_ZERO;
            end
         end
         else if (start == `START_STOP)
         begin
            // Stop clears the counter; the flip-flop keeps its level
            run_r <= 1'b0;
            cnt_r <= `CNT_ZERO;
         end
         else
         begin
            case (mode)
               `MODE_WINDOW:
               begin
                  if (tick && win_open && cnt_is_period)
                  begin
                     timer_irq <= 1'b1;
                     cnt_r <= `CNT_ZERO;
                  end
                  else if (tick && win_open)
                     cnt_r <= cnt_inc;
               end
               `MODE_PWM:
               begin
                  if (trig_edge && !run_r)
                     run_r <= 1'b1;
                  else if (trig_edge && !single)
                  begin
                     capture_compare_reg <= cnt_r;
                     timer_irq <= 1'b1;
                     cnt_r <= `CNT_ZERO;
                  end
                  else if (opp_edge && run_r)
                  begin
                     capture_compare_reg <= cnt_r;
                     timer_irq <= 1'b1;
                     if (single)
                     begin
                        run_r <= 1'b0;
                        cnt_r <= `CNT_ONE;
                     end
                  end
                  else if (run_r && tick)
                     cnt_r <= cnt_inc;
               end
               `MODE_PPG:
               begin
                  if (!run_r && (start == `START_CMD || trig_edge))
                     run_r <= 1'b1;
                  else if (run_r && tick)
                  begin
                     if (cnt_is_period)
                     begin
                        ff_r <= ~ff_r;
                        inv_r <= ~inv_r;
                        timer_irq <= 1'b1;
                        cnt_r <= `CNT_ZERO;
                        if (oneshot)
                        begin
                           timer_control_reg[`START_MSB:`START_LSB] <= `START_STOP;
                           run_r <= 1'b0;
                        end
                     end
                     else if (cnt_is_cmp)
                     begin
                        ff_r <= ~ff_r;
                        inv_r <= ~inv_r;
                        timer_irq <= 1'b1;
                        cnt_r <= cnt_inc;
                     end
                     else
                        cnt_r <= cnt_inc;
                  end
               end
               default:
               begin
                  run_r <= 1'b0;
                  cnt_r <= `CNT_ZERO;
               end
            endcase
         end
      end
   end
endmodule

// *** verif/timer_window_capture_ppg_props.sv ***
// Checker: bus handshakes, interrupt pulse width, pulse pin after reset.
// Sees only the timer top ports; bound to every timer instance below.
module timer_window_capture_ppg_props
(
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Bus
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // Timer pins
   input wire pulse_output_pin,
   input wire timer_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   AST_WR_ANSWER: assert property (wr_take |=> ##[0:1] s_axi_bvalid)
      else $error("write response missing");
   AST_RD_ANSWER: assert property (rd_take |=> s_axi_rvalid)
      else $error("read data missing");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped or changed");
   AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_R_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   AST_IRQ_PULSE: assert property (timer_irq |=> !timer_irq)
      else $error("interrupt longer than one cycle");
   AST_PIN_RESET: assert property ($rose(aresetn) |-> pulse_output_pin && !timer_irq)
      else $error("pulse pin not high after reset");
endmodule

bind timer_window_capture_ppg timer_window_capture_ppg_props props_u (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .pulse_output_pin, .timer_irq);

// *** verif/pulse_source.sv ***
// Pulse source model driving the timer input pin.
// Square wave of HALF cycles a level while run is high; the level holds when stopped.
module pulse_source #(
   parameter int HALF = 20
)
(
   // Clock
   input wire aclk,
   // Control
   input wire run,
   // Pin
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_r = 0;
   logic lvl_r = 1'h0;
   assign pin = lvl_r;
   // Edges stay many source ticks apart so no window or pulse is lost
   always @(posedge aclk)
   begin
      cnt_r <= run ? (cnt_r + 1) % HALF : 0;
      if (run && cnt_r == HALF - 1)
         lvl_r <= ~lvl_r;
   end
endmodule

// *** verif/timer_window_capture_ppg_tb.sv ***
// Testbench: register map, window counting, pulse capture and pulse output.
// Bus driven at rising edges; the pulse source model feeds the input pin.
`include "timer_window_capture_ppg_defs.vh"
module timer_window_capture_ppg_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] r;} row_t;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, src_run = 1'h0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire timer_input_pin, pulse_output_pin, timer_irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   int irq_n = 0;
   row_t rows [4] = '{'{`ADDR_CTRL, 32'hFFFFFC80, 32'h80, `RESP_OKAY},
      '{`ADDR_PERIOD, 32'h1234ABCD, 32'hABCD, `RESP_OKAY},
      '{`ADDR_STATUS, 32'hFFFFFFFF, 32'h20000, `RESP_OKAY},
      '{8'h10, 32'h1, 32'h0, `RESP_SLVERR}};

   timer_window_capture_ppg #(.SHIFT0(1)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .timer_input_pin, .pulse_output_pin, .timer_irq);
   pulse_source src_u (.aclk, .run(src_run), .pin(timer_input_pin));

   initial
      forever #2 aclk = ~aclk;

   task report_and_stop();
      $display("Mismatches %0d, checks %0d", bad_count, checks);
      if (bad_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task check_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task check_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      checks++;
      if ((got >= lo && got <= hi) !== 1'h1)
      begin
         bad_count++;
         $display("Error at %0t: got %h, expected %h to %h", $time, got, lo, hi);
      end
   endtask

   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (timer_irq === 1'h1)
         irq_n <= irq_n + 1;
      if (cyc == 30000)
      begin
         bad_count++;
         report_and_stop();
      end
   end

   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `RESP_OKAY);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'h0;
      end
      while (s_axi_bvalid !== 1'h1);
      check({30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'h0;
   endtask

   task rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = `RESP_OKAY);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'h0;
      end
      while (s_axi_rvalid !== 1'h1);
      d = s_axi_rdata;
      check({30'h0, s_axi_rresp}, {30'h0, er});
      s_axi_rready <= 1'h0;
   endtask

   // Waits for an interrupt, then reads the capture before the next trigger
   task cap(output logic [31:0] d);
      do
         @(posedge aclk);
      while (timer_irq !== 1'h1);
      rd(`ADDR_CMP, d);
   endtask

   task pin_edge(output int n);
      logic p;
      p = pulse_output_pin;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (pulse_output_pin === p);
   endtask

   initial
   begin
      logic [31:0] v, c1, c2, c3;
      int n, n0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      check_bit(pulse_output_pin, 1'h1);
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].w, rows[i].r);
         rd(rows[i].a, v, rows[i].r);
         check(v, rows[i].e);
      end
      // Byte lane 1 only: the low byte keeps its old value
      s_axi_wstrb <= 4'h2;
      wr(`ADDR_PERIOD, 32'h00001200);
      s_axi_wstrb <= 4'hF;
      rd(`ADDR_PERIOD, v);
      check(v, 32'h12CD);
      // Window: period 3, positive then negative polarity
      wr(`ADDR_PERIOD, 32'h3);
      wr(`ADDR_CTRL, 32'h41);
      n0 = irq_n;
      repeat (40) @(posedge aclk);
      check(irq_n - n0, 32'h0);
      src_run <= 1'h1;
      repeat (90) @(posedge aclk);
      src_run <= 1'h0;
      check_rng(irq_n - n0, 32'h4, 32'h6);
      wr(`ADDR_CTRL, 32'h61);
      n0 = irq_n;
      repeat (40) @(posedge aclk);
      check_rng(irq_n - n0, 32'h4, 32'h6);
      // Single-edge capture, rising trigger
      wr(`ADDR_PERIOD, 32'hFFFF);
      wr(`ADDR_CTRL, 32'hC2);
      src_run <= 1'h1;
      cap(c1);
      cap(c2);
      cap(c3);
      check(c2, c1 + 32'h1);
      check(c3, c2);
      check_rng(c2, 32'h8, 32'hC);
      n0 = irq_n;
      repeat (80) @(posedge aclk);
      check(irq_n - n0, 32'h2);
      // Double-edge capture; the first two captures are discarded
      wr(`ADDR_CTRL, 32'h0);
      wr(`ADDR_CTRL, 32'h42);
      cap(c1);
      cap(c2);
      cap(c3);
      cap(v);
      // Single-edge capture, falling trigger: measures the low level
      wr(`ADDR_CTRL, 32'h0);
      wr(`ADDR_CTRL, 32'hE2);
      cap(c1);
      cap(c2);
      src_run <= 1'h0;
      check_rng(c3, 32'h8, 32'hB);
      check_rng(v, 32'h12, 32'h15);
      check_rng(c1, 32'h8, 32'hB);
      check(c2, c1 + 32'h1);
      // Continuous pulse output: compare 2, period 9
      wr(`ADDR_CTRL, 32'h0);
      wr(`ADDR_CTRL, 32'h3);
      // Written while stopped, so never below the running count
      wr(`ADDR_PERIOD, 32'h9);
      wr(`ADDR_CMP, 32'h2);
      check_bit(pulse_output_pin, 1'h1);
      wr(`ADDR_CTRL, 32'h23);
      pin_edge(n);
      n0 = irq_n;
      pin_edge(n);
      check(n, 32'hE);
      pin_edge(n);
      check(n, 32'h6);
      check(irq_n - n0, 32'h2);
      wr(`ADDR_CTRL, 32'h3);
      repeat (30) @(posedge aclk);
      check_bit(pulse_output_pin, 1'h0);
      wr(`ADDR_CTRL, 32'h203);
      repeat (2) @(posedge aclk);
      check_bit(pulse_output_pin, 1'h1);
      // Reset while the output runs and sits low
      wr(`ADDR_CTRL, 32'h223);
      pin_edge(n);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      check_bit(pulse_output_pin, 1'h1);
      rd(`ADDR_CTRL, v);
      check(v, 32'h0);
      // One-shot started by a rising input edge
      wr(`ADDR_CTRL, 32'h103);
      wr(`ADDR_PERIOD, 32'h9);
      wr(`ADDR_CMP, 32'h2);
      wr(`ADDR_CTRL, 32'h143);
      n0 = irq_n;
      repeat (20) @(posedge aclk);
      check_bit(pulse_output_pin, 1'h1);
      src_run <= 1'h1;
      pin_edge(n);
      pin_edge(n);
      check(n, 32'hE);
      repeat (60) @(posedge aclk);
      check_bit(pulse_output_pin, 1'h1);
      check(irq_n - n0, 32'h2);
      rd(`ADDR_CTRL, v);
      check(v, 32'h103);
      report_and_stop();
   end
endmodule
